// file: rtl/gam_pin_mux.sv
/*
 Pin multiplexer for nine general purpose pins with partition reset,
 failover, hot-plug, expander interrupt and link status alternates, plus
 strap capture, a small register port and one interrupt.
 Assumes pins are resolved outside: a pin is driven low-true enable,
 pin_oe_n low while driven. Straps are static after reset release.
*/
// Local design decisions: the plain strobed port and the register addresses.
// How it works
// - Unselected pins act as software GPIO
// - Pins 0-3 alt1 bidirectional partition resets
// - Failover event on either edge when enabled
// - Failover 0,1,2,3 from pins 4,6,7,6alt2
// - Link-up outputs on pins 0,2,4,7
// - Link-active outputs on pins 1,3,5,8
// - Pin 5 alt1 drives hot-plug event output
// - Four stack straps set their stack configuration
// - Two-bit strap sets port clocking mode
`timescale 1ns/1ps
`include "gam_defines.svh"

module gam_pin_mux
   import gam_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // Register port
   input  wire gam_pkg::gam_addr_t    reg_addr,
   input  wire gam_pkg::gam_data_t    reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [31:0]                reg_rdata,
   // Pins
   input  wire logic [8:0]            pin_in,
   output logic [8:0]                 pin_out,
   output logic [8:0]                 pin_oe_n,
   // Link state, true when up or active
   input  wire logic [3:0]            link_up,
   input  wire logic [3:0]            link_active,
   // Hot-plug event source, active low
   input  wire logic                  hotplug_event_out_n,
   // Straps
   input  wire logic [3:0]            stack_config_strap,
   input  wire logic [1:0]            port_clocking_select,
   input  wire logic                  refclk_freq_select,
   input  wire logic [3:0]            switch_operating_strap,
   // Results
   output logic [3:0]                 partition_reset,
   output logic [3:0]                 redundancy_event,
   output logic [3:0]                 stack_config,
   output logic [1:0]                 port_clock_mode,
   output logic                       refclk_is_125,
   output logic [3:0]                 switch_mode,
   output logic                       irq
);
   import gam_pkg::*;

   logic [17:0] sel_q, sel_d;
   logic [8:0]  out_q, out_d, oe_q, oe_d, mask_q, mask_d;
   logic [8:0]  st_q, st_d;
   logic [3:0]  foen_q, foen_d, prst_q, prst_d;
   logic [8:0]  s1_q, s2_q, s3_q;
   logic        cap_q;
   logic [1:0]  wait_q;
   logic [10:0] strap_q, strp1_q, strp2_q;
   logic [31:0] rdata_q, rdata_d;
   logic [3:0]  fo_lvl, fo_prev, fo_edge;
   logic [3:0]  prst_in, prst_prev, prst_edge;
   logic [8:0]  fn_alt1, fn_alt2;
   logic        exp_ev;

   // Port order for link status: 16, 4, 0, 8 on pin pairs 0/1 .. 7/8
   always_comb begin
      for (int i = 0; i < `GAM_NPIN; i++) begin
         fn_alt1[i] = (gam_fn_e'(sel_q[2*i +: 2]) == GAM_FN_ALT1);
         fn_alt2[i] = (gam_fn_e'(sel_q[2*i +: 2]) == GAM_FN_ALT2);
      end
   end

   // Pin synchroniser, s3 holds the previous stable sample
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= 9'h1FF;
         s2_q <= 9'h1FF;
         s3_q <= 9'h1FF;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_comb begin
      fo_lvl  = {s2_q[6], s2_q[7], s2_q[6], s2_q[4]};
      fo_prev = {s3_q[6], s3_q[7], s3_q[6], s3_q[4]};
      fo_edge[0] = fn_alt1[4] && foen_q[0] && (fo_lvl[0] != fo_prev[0]);
      fo_edge[1] = fn_alt1[6] && foen_q[1] && (fo_lvl[1] != fo_prev[1]);
      fo_edge[2] = fn_alt1[7] && foen_q[2] && (fo_lvl[2] != fo_prev[2]);
      fo_edge[3] = fn_alt2[6] && foen_q[3] && (fo_lvl[3] != fo_prev[3]);
      exp_ev = fn_alt1[8] && !s2_q[8] && s3_q[8];
      for (int p = 0; p < 4; p++) begin
         prst_in[p]   = fn_alt1[p] && !s2_q[p];
         prst_prev[p] = fn_alt1[p] && !s3_q[p];
         prst_edge[p] = prst_in[p] && !prst_prev[p];
      end
   end

   // Pin drive
   always_comb begin
      for (int i = 0; i < `GAM_NPIN; i++) begin
         pin_out[i]  = out_q[i];
         pin_oe_n[i] = !oe_q[i];
         // Reserved code releases the pin as well
         if (gam_fn_e'(sel_q[2*i +: 2]) != GAM_FN_GPIO) begin
            pin_out[i]  = 1'b1;
            pin_oe_n[i] = 1'b1;
         end
      end
      for (int p = 0; p < 4; p++) begin
         if (fn_alt1[p]) begin
            pin_out[p]  = 1'b0;
            pin_oe_n[p] = !prst_q[p];
         end
         if (p < 3 && fn_alt2[2*p]) begin
            pin_out[2*p]  = !link_up[p];
            pin_oe_n[2*p] = 1'b0;
         end
         if (p < 3 && fn_alt2[2*p+1]) begin
            pin_out[2*p+1]  = !link_active[p];
            pin_oe_n[2*p+1] = 1'b0;
         end
      end
      if (fn_alt1[5]) begin
         pin_out[5]  = hotplug_event_out_n;
         pin_oe_n[5] = 1'b0;
      end
      if (fn_alt2[7]) begin
         pin_out[7]  = !link_up[3];
         pin_oe_n[7] = 1'b0;
      end
      if (fn_alt2[8]) begin
         pin_out[8]  = !link_active[3];
         pin_oe_n[8] = 1'b0;
      end
   end

   // Registers
   always_comb begin
      sel_d   = sel_q;
      out_d   = out_q;
      oe_d    = oe_q;
      mask_d  = mask_q;
      foen_d  = foen_q;
      prst_d  = prst_q;
      st_d    = st_q;
      rdata_d = 32'h00000000;
      if (reg_wr) begin
         unique case (reg_addr)
            `GAM_OFF_SEL_LO: sel_d[8:0]  = reg_wdata[8:0];
            `GAM_OFF_SEL_HI: sel_d[17:9] = reg_wdata[8:0];
            `GAM_OFF_OUT:    out_d  = reg_wdata[8:0];
            `GAM_OFF_OE:     oe_d   = reg_wdata[8:0];
            `GAM_OFF_FO_EN:  foen_d = reg_wdata[3:0];
            `GAM_OFF_STATUS: st_d   = st_q & ~reg_wdata[8:0];
            `GAM_OFF_MASK:   mask_d = reg_wdata[8:0];
            `GAM_OFF_PRST:   prst_d = reg_wdata[3:0];
            default: ;
         endcase
      end
      // Set wins over a clear in the same cycle
      st_d[`GAM_ST_FO3:`GAM_ST_FO0] = st_d[`GAM_ST_FO3:`GAM_ST_FO0] | fo_edge;
      st_d[`GAM_ST_EXP] = st_d[`GAM_ST_EXP] | exp_ev;
      st_d[8:`GAM_ST_PRST0] = st_d[8:`GAM_ST_PRST0] |
                              prst_edge;
      if (reg_rd) begin
         unique case (reg_addr)
            `GAM_OFF_SEL_LO: rdata_d = {23'h0, sel_q[8:0]};
            `GAM_OFF_SEL_HI: rdata_d = {23'h0, sel_q[17:9]};
            `GAM_OFF_OUT:    rdata_d = {23'h0, out_q};
            `GAM_OFF_OE:     rdata_d = {23'h0, oe_q};
            `GAM_OFF_IN:     rdata_d = {23'h0, s2_q};
            `GAM_OFF_FO_EN:  rdata_d = {28'h0, foen_q};
            `GAM_OFF_STATUS: rdata_d = {23'h0, st_q};
            `GAM_OFF_MASK:   rdata_d = {23'h0, mask_q};
            `GAM_OFF_STRAP:  rdata_d = {21'h0, strap_q};
            `GAM_OFF_PRST:   rdata_d = {28'h0, prst_q};
            default:         rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sel_q   <= `GAM_RST_SEL;
         out_q   <= `GAM_RST_OUT;
         oe_q    <= `GAM_RST_OE;
         mask_q  <= `GAM_RST_MASK;
         foen_q  <= `GAM_RST_FO_EN;
         prst_q  <= `GAM_RST_PRST;
         st_q    <= 9'h000;
         rdata_q <= 32'h00000000;
      end else begin
         sel_q   <= sel_d;
         out_q   <= out_d;
         oe_q    <= oe_d;
         mask_q  <= mask_d;
         foen_q  <= foen_d;
         prst_q  <= prst_d;
         st_q    <= st_d;
         rdata_q <= rdata_d;
      end
   end

   // Strap pins pass two flops before anything reads them
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         strp1_q <= 11'h000;
         strp2_q <= 11'h000;
      end else begin
         strp1_q <= {switch_operating_strap, refclk_freq_select,
                     port_clocking_select, stack_config_strap};
         strp2_q <= strp1_q;
      end
   end

   // Straps caught once, after the synchroniser has filled
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_q  <= 2'h0;
         cap_q   <= 1'b0;
         strap_q <= 11'h000;
      end else if (!cap_q) begin
         if (wait_q == `GAM_STRAP_WAIT) begin
            cap_q   <= 1'b1;
            strap_q <= strp2_q;
         end else begin
            wait_q  <= wait_q + 2'h1;
         end
      end
   end

   always_comb begin
      reg_rdata        = rdata_q;
      stack_config     = strap_q[3:0];
      port_clock_mode  = strap_q[5:4];
      refclk_is_125    = strap_q[6];
      switch_mode      = strap_q[10:7];
      partition_reset  = prst_in | (prst_q & fn_alt1[3:0]);
      redundancy_event = fo_edge;
      irq              = |(st_q & mask_q);
   end

   a_fo_edge_evt: assert property (@(posedge clk) disable iff (sys_rst)
      (fn_alt1[4] && foen_q[0] && s2_q[4] != s3_q[4]) |-> ##1 st_q[0])
      else $error("failover 0 edge not recorded");
   a_fo_disabled: assert property (@(posedge clk) disable iff (sys_rst)
      !foen_q[1] |-> !redundancy_event[1])
      else $error("failover 1 event while disabled");
   a_fo3_map: assert property (@(posedge clk) disable iff (sys_rst)
      redundancy_event[3] |-> (fn_alt2[6] && $changed(s2_q[6])))
      else $error("failover 3 not from pin 6");
   a_link_up_pin: assert property (@(posedge clk) disable iff (sys_rst)
      fn_alt2[0] |-> (pin_out[0] == !link_up[0] && !pin_oe_n[0]))
      else $error("port 16 link up wrong");
   a_link_act_pin: assert property (@(posedge clk) disable iff (sys_rst)
      fn_alt2[8] |-> (pin_out[8] == !link_active[3] && !pin_oe_n[8]))
      else $error("port 8 link active wrong");
   a_hotplug_pin: assert property (@(posedge clk) disable iff (sys_rst)
      fn_alt1[5] |-> (pin_out[5] == hotplug_event_out_n && !pin_oe_n[5]))
      else $error("hot-plug output wrong");
   a_exp_input: assert property (@(posedge clk) disable iff (sys_rst)
      fn_alt1[8] |-> pin_oe_n[8])
      else $error("expander pin driven");
   a_prst_in: assert property (@(posedge clk) disable iff (sys_rst)
      (fn_alt1[2] && $fell(s2_q[2])) |-> partition_reset[2] ##1 st_q[7])
      else $error("partition 2 reset missed");
   a_gpio_drive: assert property (@(posedge clk) disable iff (sys_rst)
      (sel_q[13:12] == 2'b00) |-> (pin_oe_n[6] == !oe_q[6]
         && pin_out[6] == out_q[6]))
      else $error("gpio 6 drive wrong");
   a_strap_hold: assert property (@(posedge clk) disable iff (sys_rst)
      $past(cap_q) |-> $stable(switch_mode) && $stable(stack_config))
      else $error("strap changed after capture");
   a_fo3_input: assert property (@(posedge clk) disable iff (sys_rst)
      fn_alt2[6] |-> pin_oe_n[6])
      else $error("failover 3 pin driven");
   a_prst_force: assert property (@(posedge clk) disable iff (sys_rst)
      (fn_alt1[3] && prst_q[3]) |-> (!pin_oe_n[3] && !pin_out[3]
         && partition_reset[3]))
      else $error("partition 3 force not driven");
   a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
      (st_q[4] && mask_q[4]) |-> irq)
      else $error("interrupt not raised");
   a_rsvd_release: assert property (@(posedge clk) disable iff (sys_rst)
      (sel_q[9:8] == 2'b11) |-> (pin_oe_n[4] && pin_out[4]))
      else $error("reserved pin 4 driven");
   a_exp_status: assert property (@(posedge clk) disable iff (sys_rst)
      (fn_alt1[8] && $fell(s2_q[8])) |-> ##1 st_q[4])
      else $error("expander edge not recorded");
endmodule

// file: rtl/gam_defines.svh
/*
 Holds the offsets, field positions, reset values and timing counts of the
 general purpose pin multiplexer.
 Assumes it is included by bare name from the package and the design file.
*/
`ifndef GAM_DEFINES_SVH
`define GAM_DEFINES_SVH

`define GAM_NPIN          9
`define GAM_CLK_MHZ       50
// Register offsets on the control port
`define GAM_OFF_SEL_LO    4'h0
`define GAM_OFF_SEL_HI    4'h1
`define GAM_OFF_OUT       4'h2
`define GAM_OFF_OE        4'h3
`define GAM_OFF_IN        4'h4
`define GAM_OFF_FO_EN     4'h5
`define GAM_OFF_STATUS    4'h6
`define GAM_OFF_MASK      4'h7
`define GAM_OFF_STRAP     4'h8
`define GAM_OFF_PRST      4'h9
// Status bit positions
`define GAM_ST_FO0        0
`define GAM_ST_FO3        3
`define GAM_ST_EXP        4
`define GAM_ST_PRST0      5
`define GAM_ST_W          9
// Reset values
`define GAM_RST_SEL       18'h00000
`define GAM_RST_OUT       9'h1FF
`define GAM_RST_OE        9'h000
`define GAM_RST_FO_EN     4'h0
`define GAM_RST_MASK      9'h000
`define GAM_RST_PRST      4'h0
// Timing counts
`define GAM_STRAP_WAIT    2'h2

`endif

// file: rtl/gam_pkg.sv
/*
 Types shared by the pin multiplexer.
 Assumes gam_defines.svh is on the include path.
*/
package gam_pkg;
   `include "gam_defines.svh"

   typedef enum logic [1:0] {
      GAM_FN_GPIO = 2'b00,
      GAM_FN_ALT1 = 2'b01,
      GAM_FN_ALT2 = 2'b10,
      GAM_FN_RSVD = 2'b11
   } gam_fn_e;

   typedef logic [3:0] gam_addr_t;
   typedef logic [31:0] gam_data_t;
endpackage

// file: verif/gam_board_model.sv
/*
 Board beside the pin multiplexer: pull-ups, external drivers, straps.
 Assumes the bench steers drv_en and drv_val; pins resolve here.
*/
`timescale 1ns/1ps
module gam_board_model #(
   parameter logic [10:0] STRAPS = 11'h4EA
) (
   // Device pins
   input  wire logic [8:0] pin_out,
   input  wire logic [8:0] pin_oe_n,
   output logic [8:0]      pin_in,
   // Expander, failover and reset sources
   input  wire logic [8:0] drv_en,
   input  wire logic [8:0] drv_val,
   // Straps
   output logic [3:0]      stack_config_strap,
   output logic [1:0]      port_clocking_select,
   output logic            refclk_freq_select,
   output logic [3:0]      switch_operating_strap
);
   // Device drive wins; an undriven pin floats to its pull-up
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (~drv_en | drv_val));
   // Straps never move, before or after reset release
   assign {switch_operating_strap, refclk_freq_select, port_clocking_select,
           stack_config_strap} = STRAPS;
endmodule

// file: verif/tb_top.sv
/*
 Self-checking bench for the pin multiplexer and its register port.
 Assumes gam_pkg and gam_board_model are compiled ahead of it.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("Error t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
   import gam_pkg::*;
   localparam logic [10:0] STRAPS = 11'h4EA;
   logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        hotplug_event_out_n = 1'b1, irq, refclk_freq_select;
   gam_addr_t   reg_addr = 4'h0;
   gam_data_t   reg_wdata = 32'h0, st;
   logic [31:0] reg_rdata;
   logic [8:0]  pin_in, pin_out, pin_oe_n;
   logic [8:0]  drv_en = 9'h000, drv_val = 9'h000;
   logic [3:0]  link_up = 4'h0, link_active = 4'h0, stack_config_strap;
   logic [3:0]  switch_operating_strap, partition_reset, redundancy_event;
   logic [3:0]  stack_config, switch_mode;
   logic [1:0]  port_clocking_select, port_clock_mode;
   logic        refclk_is_125;
   int          error_cnt = 0, cmp_count = 0;

   gam_pin_mux dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe_n, .link_up,
      .link_active, .hotplug_event_out_n, .stack_config_strap,
      .port_clocking_select, .refclk_freq_select, .switch_operating_strap,
      .partition_reset, .redundancy_event, .stack_config, .port_clock_mode,
      .refclk_is_125, .switch_mode, .irq);
   gam_board_model #(.STRAPS(STRAPS)) brd_u (.pin_out, .pin_oe_n, .pin_in,
      .drv_en, .drv_val, .stack_config_strap, .port_clocking_select,
      .refclk_freq_select, .switch_operating_strap);

   always #10 clk = ~clk;

   task automatic close_out(input bit hang);
      if (hang) error_cnt++;
      $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wr(input gam_addr_t a, input gam_data_t d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input gam_addr_t a, output gam_data_t d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic drive(input logic [8:0] en, input logic [8:0] val);
      @(posedge clk);
      drv_en  <= en;
      drv_val <= val;
   endtask

   // Catches the one-cycle failover pulse within a bounded window
   task automatic wait_ev(input logic [3:0] exp);
      int i;
      for (i = 0; i < 10; i++) begin
         settle(1);
         if (redundancy_event !== 4'h0) break;
      end
      if (i == 10) close_out(1'b1);
      `CHK(redundancy_event, exp)
   endtask

   task automatic t_reset();
      `CHK(pin_oe_n, 9'h1FF)
      rd(4'h2, st);
      `CHK(st, 32'h1FF)
      rd(4'hF, st);
      `CHK(st, 32'h0)
      rd(4'h8, st);
      `CHK(st, {21'h0, STRAPS})
      `CHK(stack_config, STRAPS[3:0])
      `CHK(port_clock_mode, STRAPS[5:4])
      `CHK(refclk_is_125, STRAPS[6])
      `CHK(switch_mode, STRAPS[10:7])
      $display("reset and straps done");
   endtask

   task automatic t_gpio();
      wr(4'h2, 32'h0A5);
      wr(4'h3, 32'h0F0);
      drive(9'h00F, 9'h006);
      settle(4);
      `CHK(pin_oe_n, 9'h10F)
      `CHK(pin_out & 9'h0F0, 9'h0A0)
      rd(4'h4, st);
      `CHK(st, 32'h1A6)
      wr(4'h3, 32'h0);
      drive(9'h000, 9'h000);
      $display("gpio done");
   endtask

   task automatic t_link();
      @(posedge clk);
      link_up     <= 4'h5;
      link_active <= 4'h3;
      wr(4'h0, 32'h0AA);
      wr(4'h1, 32'h155);
      settle(2);
      `CHK(pin_oe_n, 9'h040)
      `CHK(pin_out & 9'h1BF, 9'h1A4)
      @(posedge clk);
      link_up     <= 4'hA;
      link_active <= 4'hC;
      settle(2);
      `CHK(pin_out & 9'h1BF, 9'h01B)
      $display("link status done");
   endtask

   task automatic t_alt1();
      wr(4'h0, 32'h155);
      wr(4'h1, 32'h0AA);
      hotplug_event_out_n <= 1'b0;
      drive(9'h004, 9'h000);
      settle(5);
      `CHK(pin_oe_n, 9'h1DF)
      `CHK(pin_out[5], 1'b0)
      `CHK(partition_reset, 4'h4)
      drive(9'h000, 9'h000);
      wr(4'h9, 32'h8);
      settle(5);
      `CHK(pin_oe_n[3], 1'b0)
      `CHK(partition_reset, 4'h8)
      rd(4'h6, st);
      `CHK(st[8:7], 2'h3)
      wr(4'h9, 32'h0);
      $display("partition reset done");
   endtask

   task automatic t_fail();
      wr(4'h5, 32'h0);
      drive(9'h010, 9'h000);
      settle(6);
      rd(4'h6, st);
      `CHK(st[3:0], 4'h0)
      wr(4'h5, 32'hF);
      drive(9'h010, 9'h010);
      wait_ev(4'h1);
      drive(9'h050, 9'h010);
      wait_ev(4'h2);
      drive(9'h0D0, 9'h010);
      wait_ev(4'h4);
      wr(4'h1, 32'h0B2);
      drive(9'h0D0, 9'h050);
      wait_ev(4'h8);
      $display("failover done");
   endtask

   task automatic t_irq();
      wr(4'h6, 32'h1FF);
      wr(4'h7, 32'h010);
      drive(9'h100, 9'h000);
      settle(6);
      `CHK(irq, 1'b1)
      wr(4'h7, 32'h0);
      settle(1);
      `CHK(irq, 1'b0)
      wr(4'h6, 32'h010);
      wr(4'h7, 32'h010);
      settle(1);
      `CHK(irq, 1'b0)
      $display("interrupt done");
   endtask

   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      settle(2);
      t_reset();
      t_gpio();
      t_link();
      t_alt1();
      t_fail();
      t_irq();
      close_out(1'b0);
   end
endmodule
